// *** rtl/adc_parallel_sample_output.sv ***
// digital output side of a pipelined converter: sampling, formatting, pins
// assumes: clk is the 50 MHz system clock carrying the quantised front-end level;
// the converter clock arrives as a differential pair and runs its own domain
//
// What this block does
// - take one new sample at every rising converter clock edge.
// - present each result as a 15-bit two's-complement word.
// - bit 0 is the lsb, bit 14 the msb sign; capture maps likewise.
// - drive the overrange flag high when a conversion is overrange.
// - raise the data-valid strobe after the converter clock falling edge.
// - deliver each result three converter clock cycles after its sample edge.
// - word is stable at strobe rising edge; capture registers it there.
// - overrange flag has exactly the word's timing and latency.
`include "adc_output_cfg.svh"
`default_nettype none

module adc_parallel_sample_output (
   // system clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // quantised front-end level, system clock domain
   input wire logic [`ADC_RAW_W-1:0] analogLevel,
   // differential converter clock
   input wire logic convClockPos,
   input wire logic convClockNeg,
   // parallel sample outputs, converter clock domain
   output logic [`ADC_WORD_W-1:0] sampleBits,
   output logic overRangeFlag,
   output logic sampleValidStrobe,
   // status toward the system clock domain
   output logic convRunning,
   output logic convClockLost,
   output logic overRangeRecent,
   output logic [`STAT_CNT_W-1:0] convBlockCount
);

   localparam int LATENCY = `ADC_LATENCY;
   localparam int LOST_CYCLES = (`CONV_LOST_NS * `SYS_CLK_MHZ) / 1000;
   localparam logic [`CONV_LOST_W-1:0] LOST_LIMIT = `CONV_LOST_W'(LOST_CYCLES);

   // converter-domain reset: asserted at once, released on the converter clock
   logic convRstMeta;
   logic convRst_n;

   always_ff @(posedge convClockPos or negedge rst_n) begin
      if (!rst_n) begin
         convRstMeta <= 1'b0;
         convRst_n <= 1'b0;
      end else begin
         convRstMeta <= 1'b1;
         convRst_n <= convRstMeta;
      end
   end

   // front-end level crosses into the converter domain as a whole word
   logic [`ADC_RAW_W-1:0] crossedLevel;
   logic crossedFresh;

   word_handshake_sync levelCross (
      .srcClk(clk),
      .srcRst_n(rst_n),
      .srcWord(analogLevel),
      .srcReady(),
      .dstClk(convClockPos),
      .dstRst_n(convRst_n),
      .dstWord(crossedLevel),
      .dstFresh(crossedFresh)
   );

   // nothing is sampled until a real level has arrived
   logic haveLevel;

   always_ff @(posedge convClockPos or negedge convRst_n) begin
      if (!convRst_n) begin
         haveLevel <= 1'b0;
      end else if (crossedFresh) begin
         haveLevel <= 1'b1;
      end
   end

   // saturate to the word range and flag anything beyond full scale
   function automatic adc_output_pkg::sample_t format_sample(
      input logic [`ADC_RAW_W-1:0] level,
      input logic valid
   );
      adc_output_pkg::raw_level_t s;
      adc_output_pkg::raw_level_t posLim;
      adc_output_pkg::raw_level_t negLim;
      adc_output_pkg::sample_t r;
      s = adc_output_pkg::raw_level_t'(level);
      posLim = adc_output_pkg::raw_level_t'($signed(`ADC_POS_FULL));
      negLim = adc_output_pkg::raw_level_t'($signed(`ADC_NEG_FULL));
      r.valid = valid;
      if (s > posLim) begin
         r.code = `ADC_POS_FULL;
         r.overRange = 1'b1;
      end else if (s < negLim) begin
         r.code = `ADC_NEG_FULL;
         r.overRange = 1'b1;
      end else begin
         r.code = s[`ADC_WORD_W-1:0];
         r.overRange = 1'b0;
      end
      return r;
   endfunction

   // sample register and pipeline; one conversion per converter clock period
   adc_output_pkg::sample_t pipe [LATENCY];
   adc_output_pkg::sample_t next_sample;

   always_comb begin
      next_sample = haveLevel ? format_sample(crossedLevel, 1'b1) : '0;
   end

   always_ff @(posedge convClockPos or negedge convRst_n) begin
      if (!convRst_n) begin
         pipe[0] <= '0;
      end else begin
         pipe[0] <= next_sample;
      end
   end

   genvar g;
   generate
      for (g = 1; g < LATENCY; g++) begin : stage
         always_ff @(posedge convClockPos or negedge convRst_n) begin
            if (!convRst_n) begin
               pipe[g] <= '0;
            end else begin
               pipe[g] <= pipe[g-1];
            end
         end
      end
   endgenerate

   // output register: word and flag leave the same stage on the same edge
   logic outValid;

   always_ff @(posedge convClockPos or negedge convRst_n) begin
      if (!convRst_n) begin
         sampleBits <= `ADC_WORD_RESET;
         overRangeFlag <= 1'b0;
         outValid <= 1'b0;
      end else begin
         // bit 0 lsb through bit 14 sign, straight from the code field
         sampleBits <= pipe[LATENCY-1].code;
         overRangeFlag <= pipe[LATENCY-1].overRange;
         outValid <= pipe[LATENCY-1].valid;
      end
   end

   // strobe: set on the falling edge, cleared on the rising edge. two toggle
   // flops are xored so each edge owns one flop and the output never glitches
   logic riseTog;
   logic fallTog;

   always_ff @(posedge convClockPos or negedge convRst_n) begin
      if (!convRst_n) begin
         riseTog <= 1'b0;
      end else begin
         riseTog <= fallTog;
      end
   end

   // the rising edge of the negative leg is the falling edge of the clock
   always_ff @(posedge convClockNeg or negedge convRst_n) begin
      if (!convRst_n) begin
         fallTog <= 1'b0;
      end else if (outValid) begin
         fallTog <= ~riseTog;
      end else begin
         fallTog <= riseTog;
      end
   end

   // the word changed half a period earlier, so it is settled when this rises
   assign sampleValidStrobe = riseTog ^ fallTog;

   // heartbeat and overrange window, converter domain
   logic [`CONV_CNT_W-1:0] convCount;
   logic [`OR_WINDOW_W-1:0] orWindow;
   logic orHeld;

   always_ff @(posedge convClockPos or negedge convRst_n) begin
      if (!convRst_n) begin
         convCount <= '0;
      end else if (outValid) begin
         convCount <= convCount + `CONV_CNT_W'(1);
      end
   end

   // a single-flag level is too short to cross; stretch it over a window
   always_ff @(posedge convClockPos or negedge convRst_n) begin
      if (!convRst_n) begin
         orWindow <= '0;
         orHeld <= 1'b0;
      end else if (outValid && overRangeFlag) begin
         orWindow <= `OR_WINDOW;
         orHeld <= 1'b1;
      end else if (orWindow != '0) begin
         orWindow <= orWindow - `OR_WINDOW_W'(1);
      end else begin
         orHeld <= 1'b0;
      end
   end

   // levels into the system domain, two flops each
   logic [2:0] statMeta;
   logic [2:0] statSync;
   logic beatSeen;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         statMeta <= '0;
         statSync <= '0;
      end else begin
         statMeta <= {convCount[`BEAT_BIT], orHeld, outValid};
         statSync <= statMeta;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         beatSeen <= 1'b0;
      end else begin
         beatSeen <= statSync[2];
      end
   end

   // each heartbeat edge is four delivered conversions
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         convBlockCount <= '0;
      end else if (statSync[2] != beatSeen) begin
         convBlockCount <= convBlockCount + `STAT_CNT_W'(1);
      end
   end

   // watchdog: the converter clock may stop; a missing heartbeat shows it
   logic [`CONV_LOST_W-1:0] quietCount;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         quietCount <= '0;
         convClockLost <= 1'b0;
      end else if (statSync[2] != beatSeen) begin
         quietCount <= '0;
         convClockLost <= 1'b0;
      end else if (quietCount >= LOST_LIMIT) begin
         convClockLost <= 1'b1;
      end else begin
         quietCount <= quietCount + `CONV_LOST_W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         convRunning <= 1'b0;
         overRangeRecent <= 1'b0;
      end else begin
         convRunning <= statSync[0] && !convClockLost;
         overRangeRecent <= statSync[1];
      end
   end

endmodule

`default_nettype wire

// *** rtl/adc_output_cfg.svh ***
// constants for the parallel sample output block
// assumes: included by bare name from the package and design files
`ifndef ADC_OUTPUT_CFG_SVH
`define ADC_OUTPUT_CFG_SVH

// output word: 15 bits, two's complement, bit 0 lsb, bit 14 msb
`define ADC_WORD_W 15
`define ADC_LSB_POS 0
`define ADC_MSB_POS 14

// quantised front-end level, wider than the word so overrange shows
`define ADC_RAW_W 18

// fixed pipeline latency in converter clock cycles
`define ADC_LATENCY 3

// full-scale codes and the reset word
`define ADC_POS_FULL 15'h3fff
`define ADC_NEG_FULL 15'h4000
`define ADC_WORD_RESET 15'h0000

// system clock and the watchdog on the converter clock
`define SYS_CLK_MHZ 50
`define CONV_LOST_NS 1000
`define CONV_LOST_W 8

// heartbeat bit of the conversion counter, toggles every 4 conversions
`define BEAT_BIT 2
`define CONV_CNT_W 3
`define STAT_CNT_W 16

// overrange window length in conversions
`define OR_WINDOW 4'h8
`define OR_WINDOW_W 4

`endif

// *** rtl/adc_output_pkg.sv ***
// types shared by the sample output files
// assumes: adc_output_cfg.svh on the include path
`include "adc_output_cfg.svh"
`default_nettype none

package adc_output_pkg;

   // one result moving through the conversion pipeline
   typedef struct packed {
      logic valid;
      logic overRange;
      logic [`ADC_WORD_W-1:0] code;
   } sample_t;

   typedef logic signed [`ADC_RAW_W-1:0] raw_level_t;

endpackage

`default_nettype wire

// *** rtl/word_handshake_sync.sv ***
// two-phase toggle handshake carrying one word from clk to a second clock
// assumes: both resets asynchronous, active low, each released in its domain
`include "adc_output_cfg.svh"
`default_nettype none

module word_handshake_sync (
   // source side
   input wire logic srcClk,
   input wire logic srcRst_n,
   input wire logic [`ADC_RAW_W-1:0] srcWord,
   output logic srcReady,
   // destination side
   input wire logic dstClk,
   input wire logic dstRst_n,
   output logic [`ADC_RAW_W-1:0] dstWord,
   output logic dstFresh
);

   logic [`ADC_RAW_W-1:0] holdWord;
   logic reqTog;
   logic ackTog;
   logic reqMeta;
   logic reqSync;
   logic reqSeen;
   logic ackMeta;
   logic ackSync;

   // the held word is stable for the whole time the request is in flight
   assign srcReady = (ackSync == reqTog);

   always_ff @(posedge srcClk or negedge srcRst_n) begin
      if (!srcRst_n) begin
         holdWord <= '0;
         reqTog <= 1'b0;
      end else if (srcReady) begin
         holdWord <= srcWord;
         reqTog <= ~reqTog;
      end
   end

   always_ff @(posedge srcClk or negedge srcRst_n) begin
      if (!srcRst_n) begin
         ackMeta <= 1'b0;
         ackSync <= 1'b0;
      end else begin
         ackMeta <= ackTog;
         ackSync <= ackMeta;
      end
   end

   always_ff @(posedge dstClk or negedge dstRst_n) begin
      if (!dstRst_n) begin
         reqMeta <= 1'b0;
         reqSync <= 1'b0;
         reqSeen <= 1'b0;
      end else begin
         reqMeta <= reqTog;
         reqSync <= reqMeta;
         reqSeen <= reqSync;
      end
   end

   always_ff @(posedge dstClk or negedge dstRst_n) begin
      if (!dstRst_n) begin
         dstWord <= '0;
         ackTog <= 1'b0;
         dstFresh <= 1'b0;
      end else begin
         dstFresh <= (reqSync != reqSeen);
         if (reqSync != reqSeen) begin
            dstWord <= holdWord;
            ackTog <= reqSync;
         end
      end
   end

endmodule

`default_nettype wire

// *** testbench/adc_output_sva.sv ***
// checker for the sample output pins and the status outputs
// assumes: bound to adc_parallel_sample_output, convClockNeg driven as ~convClockPos
`include "adc_output_cfg.svh"
`default_nettype none

module adc_output_sva (
   // clocks and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic convClockPos,
   input wire logic convClockNeg,
   // pins and status
   input wire logic [`ADC_WORD_W-1:0] sampleBits,
   input wire logic overRangeFlag,
   input wire logic sampleValidStrobe,
   input wire logic convRunning,
   input wire logic [`STAT_CNT_W-1:0] convBlockCount
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [`ADC_WORD_W:0] fallOut;

   // word and flag as they stood at the falling edge, before the strobe rises
   always_ff @(posedge convClockNeg or negedge rst_n) begin
      if (!rst_n) begin
         fallOut <= '0;
      end else begin
         fallOut <= {overRangeFlag, sampleBits};
      end
   end

   sequence sStrobeTwice;
      sampleValidStrobe ##1 sampleValidStrobe;
   endsequence

   sequence sIdleOut;
      sampleBits == '0 && !overRangeFlag;
   endsequence

   a_strobe_low_phase: assert property (@(posedge convClockNeg) disable iff (!rst_n) !sampleValidStrobe)
      else $error("strobe high during converter clock high phase");
   a_strobe_clock_phase: assert property (
      @(posedge clk) disable iff (!rst_n) sampleValidStrobe |-> !convClockPos)
      else $error("strobe high while converter clock high");
   a_strobe_every_cycle: assert property (
      @(posedge convClockPos) disable iff (!rst_n) sampleValidStrobe |-> sStrobeTwice)
      else $error("strobe pulse missing in a cycle");
   a_word_held_strobe: assert property (
      @(posedge convClockPos) disable iff (!rst_n) sampleValidStrobe |-> {overRangeFlag, sampleBits} == fallOut)
      else $error("word moved while strobe high");
   a_flag_full_scale: assert property (
      @(posedge convClockPos) disable iff (!rst_n)
      overRangeFlag |-> (sampleBits == `ADC_POS_FULL || sampleBits == `ADC_NEG_FULL))
      else $error("overrange flag with a word that is not full scale");
   a_idle_word_zero: assert property (
      @(posedge convClockPos) disable iff (!rst_n) !sampleValidStrobe |-> sIdleOut)
      else $error("word shown without strobe");
   a_reset_clears: assert property (
      // judged from the second edge on; rst_n clears the converter-domain reset at once, without the converter clock
      @(posedge clk) !rst_n ##1 !rst_n |-> sampleBits == '0 && !sampleValidStrobe && !convRunning)
      else $error("outputs not cleared in reset");
   a_block_step: assert property (
      @(posedge clk) disable iff (!rst_n)
      convBlockCount != $past(convBlockCount) |-> convBlockCount == $past(convBlockCount) + 1'b1)
      else $error("block count jumped");
endmodule

bind adc_parallel_sample_output adc_output_sva adc_output_sva_i (.clk(clk), .rst_n(rst_n),
   .convClockPos(convClockPos), .convClockNeg(convClockNeg), .sampleBits(sampleBits),
   .overRangeFlag(overRangeFlag), .sampleValidStrobe(sampleValidStrobe), .convRunning(convRunning),
   .convBlockCount(convBlockCount));

`default_nettype wire

// *** testbench/sample_capture.sv ***
// capture latch standing in for the acquisition logic beyond the pins
// assumes: the strobe is its only clock, no reset reaches it
`include "adc_output_cfg.svh"
`default_nettype none

module sample_capture (
   // pins from the converter
   input wire logic [`ADC_WORD_W-1:0] sampleBits,
   input wire logic overRangeFlag,
   input wire logic sampleValidStrobe,
   // captured result
   output var adc_output_pkg::sample_t captured,
   output var logic [15:0] captureCount
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      captured = '0;
      captureCount = 16'h0000;
   end

   // strobe used as the capture clock, so the converter clock never reaches us
   always @(posedge sampleValidStrobe) begin
      captured.valid <= 1'b1;
      captured.overRange <= overRangeFlag;
      captured.code <= {sampleBits[`ADC_MSB_POS], sampleBits[`ADC_MSB_POS-1:`ADC_LSB_POS]};
      captureCount <= captureCount + 16'h0001;
   end
endmodule

`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking bench for the parallel sample output block
// assumes: design files and the capture model compiled before this file
`include "adc_output_cfg.svh"
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst_n, convClockPos, overRangeFlag, sampleValidStrobe;
   logic convRunning, convClockLost, overRangeRecent;
   logic [`ADC_RAW_W-1:0] analogLevel;
   logic [`ADC_WORD_W-1:0] sampleBits;
   logic [`STAT_CNT_W-1:0] convBlockCount;
   logic [15:0] captureCount, n, b;
   adc_output_pkg::sample_t captured, want;
   adc_output_pkg::sample_t expQ[$];
   logic [`ADC_RAW_W-1:0] edges[8];
   int err_total, compares, seed;

   adc_parallel_sample_output adc_parallel_sample_output_i (.clk(clk), .rst_n(rst_n),
      .analogLevel(analogLevel), .convClockPos(convClockPos), .convClockNeg(~convClockPos),
      .sampleBits(sampleBits), .overRangeFlag(overRangeFlag), .sampleValidStrobe(sampleValidStrobe),
      .convRunning(convRunning), .convClockLost(convClockLost), .overRangeRecent(overRangeRecent),
      .convBlockCount(convBlockCount));
   sample_capture sample_capture_i (.sampleBits(sampleBits), .overRangeFlag(overRangeFlag),
      .sampleValidStrobe(sampleValidStrobe), .captured(captured), .captureCount(captureCount));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      convClockPos = 1'b0;
      #7;
      forever #15 convClockPos = ~convClockPos;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic adc_output_pkg::sample_t model_of(input adc_output_pkg::raw_level_t lvl);
      model_of = '0;
      model_of.valid = 1'b1;
      model_of.code = lvl[`ADC_WORD_W-1:0];
      if (lvl > $signed({3'h0, `ADC_POS_FULL})) begin
         model_of.code = `ADC_POS_FULL;
         model_of.overRange = 1'b1;
      end else if (lvl < $signed({3'h7, `ADC_NEG_FULL})) begin
         model_of.code = `ADC_NEG_FULL;
         model_of.overRange = 1'b1;
      end
   endfunction

   // level held long enough to cross and fill the pipe, then the next capture is judged
   task automatic apply(input logic [`ADC_RAW_W-1:0] lvl);
      @(posedge clk);
      #2 analogLevel = lvl;
      repeat (16) @(posedge convClockPos);
      expQ.push_back(model_of(lvl));
      wait (expQ.size() == 0);
      $display("level %h done", lvl);
   endtask

   always @(posedge sampleValidStrobe) begin
      #1;
      if (expQ.size() > 0) begin
         want = expQ.pop_front();
         check(captured, want);
      end
   end

   task automatic print_verdict;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #60000;
      err_total++;
      print_verdict;
   end

   initial begin
      seed = 92;
      err_total = 0;
      compares = 0;
      rst_n = 1'b0;
      analogLevel = '0;
      edges = '{18'h00000, 18'h03fff, 18'h04000, 18'h3c000, 18'h3bfff, 18'h1ffff, 18'h3ffff, 18'h20000};
      repeat (8) @(posedge clk);
      #2 rst_n = 1'b1;
      foreach (edges[i]) apply(edges[i]);
      // status lags the pins by the window and three flops
      repeat (8) @(posedge clk);
      #2;
      check(convClockLost, 1'b0);
      check(overRangeRecent, 1'b1);
      check(convRunning, 1'b1);
      for (int k = 0; k < 6; k++) apply(18'($random(seed)));
      @(posedge convClockPos);
      n = captureCount;
      b = convBlockCount;
      repeat (10) @(posedge convClockPos);
      check(16'(captureCount - n), 16'h000a);
      // ten conversions make two or three heartbeat steps, depending on phase
      check(16'(convBlockCount - b) >> 1, 16'h0001);
      $display("strobe rate done");
      @(posedge clk);
      #2 rst_n = 1'b0;
      repeat (8) @(posedge clk);
      check({overRangeFlag, sampleBits}, 16'h0000);
      #2 rst_n = 1'b1;
      apply(18'h00123);
      print_verdict;
   end
endmodule

`default_nettype wire
